//--- pkg/codc_pkg.sv
// Purpose: Constants, types and carriers for the clock output driver control bank.
// Assumes: Plain register port with 9-bit byte address and 8-bit data.
// Notes: Six emitter-coupled outputs and four LVDS/CMOS switchable outputs.
package codc_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int CODC_NUM_PECL = 6;
    localparam int CODC_NUM_SW = 4;
    localparam int CODC_NUM_REG = 10;
    localparam int CODC_ADDR_W = 9;
    localparam int CODC_DATA_W = 8;

    typedef logic [CODC_ADDR_W-1:0] codc_addr_t;
    typedef logic [CODC_DATA_W-1:0] codc_data_t;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam codc_addr_t CODC_OFF_PECL_ZERO = 9'h0f0;
    localparam codc_addr_t CODC_OFF_PECL_ONE = 9'h0f1;
    localparam codc_addr_t CODC_OFF_PECL_TWO = 9'h0f2;
    localparam codc_addr_t CODC_OFF_PECL_THREE = 9'h0f3;
    localparam codc_addr_t CODC_OFF_PECL_FOUR = 9'h0f4;
    localparam codc_addr_t CODC_OFF_PECL_FIVE = 9'h0f5;
    localparam codc_addr_t CODC_OFF_SW_SIX = 9'h140;
    localparam codc_addr_t CODC_OFF_SW_SEVEN = 9'h141;
    localparam codc_addr_t CODC_OFF_SW_EIGHT = 9'h142;
    localparam codc_addr_t CODC_OFF_SW_NINE = 9'h143;

    localparam codc_addr_t CODC_REG_OFF [CODC_NUM_REG] = '{
        CODC_OFF_PECL_ZERO, CODC_OFF_PECL_ONE, CODC_OFF_PECL_TWO,
        CODC_OFF_PECL_THREE, CODC_OFF_PECL_FOUR, CODC_OFF_PECL_FIVE,
        CODC_OFF_SW_SIX, CODC_OFF_SW_SEVEN, CODC_OFF_SW_EIGHT, CODC_OFF_SW_NINE
    };

    // ------------------------------------------------------------
    // Reset values and write masks
    // ------------------------------------------------------------
    // Swing 780 mV, drive on
    localparam codc_data_t CODC_RST_PECL_ON = 8'h08;
    // Swing 780 mV, power-down mode 10
    localparam codc_data_t CODC_RST_PECL_OFF = 8'h0a;
    // Polarity 010, LVDS, 3.5 mA, powered down
    localparam codc_data_t CODC_RST_SW = 8'h43;
    localparam codc_data_t CODC_RD_ZERO = 8'h00;

    localparam codc_data_t CODC_RST_VAL [CODC_NUM_REG] = '{
        CODC_RST_PECL_ON, CODC_RST_PECL_OFF, CODC_RST_PECL_ON,
        CODC_RST_PECL_OFF, CODC_RST_PECL_ON, CODC_RST_PECL_OFF,
        CODC_RST_SW, CODC_RST_SW, CODC_RST_SW, CODC_RST_SW
    };

    localparam codc_data_t CODC_MASK_PECL = 8'h1f;
    localparam codc_data_t CODC_MASK_SW = 8'hff;

    localparam codc_data_t CODC_WR_MASK [CODC_NUM_REG] = '{
        CODC_MASK_PECL, CODC_MASK_PECL, CODC_MASK_PECL,
        CODC_MASK_PECL, CODC_MASK_PECL, CODC_MASK_PECL,
        CODC_MASK_SW, CODC_MASK_SW, CODC_MASK_SW, CODC_MASK_SW
    };

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CODC_PECL_INV_BIT = 4;
    localparam int CODC_PECL_SWING_LSB = 2;
    localparam int CODC_PECL_MODE_LSB = 0;
    localparam int CODC_SW_POL_LSB = 5;
    localparam int CODC_SW_COMP_EN_BIT = 4;
    localparam int CODC_SW_LEVEL_BIT = 3;
    localparam int CODC_SW_CUR_LSB = 1;
    localparam int CODC_SW_PD_BIT = 0;

    // ------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CODC_SWING_400MV,
        CODC_SWING_600MV,
        CODC_SWING_780MV,
        CODC_SWING_960MV
    } codc_swing_e;

    typedef enum logic [1:0] {
        CODC_PMODE_ON,
        CODC_PMODE_PARTIAL_PD,
        CODC_PMODE_PD_A,
        CODC_PMODE_PD_B
    } codc_pmode_e;

    typedef enum logic [1:0] {
        CODC_CUR_1P75MA,
        CODC_CUR_3P5MA,
        CODC_CUR_5P25MA,
        CODC_CUR_7P0MA
    } codc_cur_e;

    // CMOS polarity per 3-bit code, bit index is the code
    localparam logic [7:0] CODC_TRUE_INV_LUT = 8'h5a;
    localparam logic [7:0] CODC_COMP_INV_LUT = 8'h99;

    // ------------------------------------------------------------
    // Carriers to the output stages
    // ------------------------------------------------------------
    typedef struct packed {
        logic invert;
        codc_swing_e swing;
        logic drive_on;
        logic partial_pd;
        logic pins_hiz;
    } codc_pecl_s;

    typedef struct packed {
        logic cmos_mode;
        logic true_inv;
        logic comp_inv;
        logic comp_on;
        codc_cur_e lvds_cur;
        logic term_fifty;
        logic drive_on;
        logic lvds_hiz;
        logic cmos_low;
    } codc_sw_s;

endpackage : codc_pkg

//--- rtl/codc_sw_decode.sv
// Purpose: Decode one switchable output control byte into stage controls.
// Assumes: Control byte comes straight from the register bank.
// Notes: Outputs are registered, one clock behind the control byte.
`timescale 1ns/100ps
module codc_sw_decode (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire codc_pkg::codc_data_t ctrl_i,
    output codc_pkg::codc_sw_s stage_o
);
    import codc_pkg::*;

    // ------------------------------------------------------------
    // Field split
    // ------------------------------------------------------------
    wire logic [2:0] pol_code;
    wire logic is_cmos;
    wire logic pwr_down;
    wire logic comp_req;
    wire codc_cur_e cur_code;
    codc_sw_s stage_nxt;
    codc_sw_s stage_r;

    assign pol_code = ctrl_i[CODC_SW_POL_LSB +: 3];
    assign is_cmos = ctrl_i[CODC_SW_LEVEL_BIT];
    assign pwr_down = ctrl_i[CODC_SW_PD_BIT];
    assign comp_req = ctrl_i[CODC_SW_COMP_EN_BIT];
    assign cur_code = codc_cur_e'(ctrl_i[CODC_SW_CUR_LSB +: 2]);

    // ------------------------------------------------------------
    // Stage controls
    // ------------------------------------------------------------
    // LVDS reads only the low polarity bit
    assign stage_nxt.cmos_mode = is_cmos;
    assign stage_nxt.true_inv = is_cmos ? CODC_TRUE_INV_LUT[pol_code]
                                        : pol_code[0];
    assign stage_nxt.comp_inv = is_cmos & CODC_COMP_INV_LUT[pol_code];
    // Complementary pin exists only in CMOS and only when powered
    assign stage_nxt.comp_on = is_cmos & comp_req & ~pwr_down;
    // Current is meaningless in CMOS, so it is forced to the lowest code
    assign stage_nxt.lvds_cur = is_cmos ? CODC_CUR_1P75MA : cur_code;
    assign stage_nxt.term_fifty = ~is_cmos & cur_code[1];
    assign stage_nxt.drive_on = ~pwr_down;
    assign stage_nxt.lvds_hiz = pwr_down & ~is_cmos;
    assign stage_nxt.cmos_low = pwr_down & is_cmos;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stage_r <= '0;
        end else begin
            stage_r <= stage_nxt;
        end
    end

    assign stage_o = stage_r;

endmodule : codc_sw_decode

//--- rtl/codc_bank.sv
// Purpose: Register bank steering the ten clock output drivers.
// Assumes: Plain register port, strobes one cycle, never both at once.
// Notes: Stage controls follow a write by two clocks; read data one clock after.
`timescale 1ns/100ps

// Notes on behaviour
// - Bit 4 of an emitter-coupled output register inverts that output when set.
// - Bits 3:2 of an emitter-coupled register pick 400, 600, 780 or 960 mV swing.
// - Bits 1:0 of an emitter-coupled register: 00 runs, any other code turns pins high-Z.
// - Emitter-coupled outputs one, three and five reset with mode 10, the others with 00.
// - Switchable bits 7:5 set polarity, and LVDS looks only at bit 5.
// - In CMOS mode the 3-bit polarity code decodes per table into true and comp pin inversion.
// - Switchable bit 4 turns on the complementary CMOS pin, and does nothing in LVDS.
// - Switchable bit 3 picks LVDS at 0 and CMOS at 1.
// - Switchable bits 2:1 set LVDS current 1.75 to 7.0 mA, ignored in CMOS.
// - Switchable bit 0 powers down: LVDS goes high-Z and CMOS drives low.
module codc_bank (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire codc_pkg::codc_addr_t reg_addr_i,
    input wire codc_pkg::codc_data_t reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output codc_pkg::codc_data_t reg_rdata_o,
    output codc_pkg::codc_pecl_s [codc_pkg::CODC_NUM_PECL-1:0] pecl_ctrl_o,
    output codc_pkg::codc_sw_s [codc_pkg::CODC_NUM_SW-1:0] sw_ctrl_o
);
    import codc_pkg::*;

    // ------------------------------------------------------------
    // Storage and decode
    // ------------------------------------------------------------
    codc_data_t reg_mem_r [CODC_NUM_REG];
    codc_data_t reg_mem_nxt [CODC_NUM_REG];
    wire logic [CODC_NUM_REG-1:0] addr_hit;
    wire codc_data_t rd_chain [CODC_NUM_REG+1];
    wire codc_data_t rd_sel;
    codc_data_t rdata_r;
    codc_data_t rdata_nxt;

    assign rd_chain[0] = CODC_RD_ZERO;

    genvar gi;
    generate
        for (gi = 0; gi < CODC_NUM_REG; gi++) begin : g_reg
            assign addr_hit[gi] = (reg_addr_i == CODC_REG_OFF[gi]);
            // Masked bits never store, so they read back zero
            assign reg_mem_nxt[gi] = (reg_wr_i && addr_hit[gi])
                                     ? (reg_wdata_i & CODC_WR_MASK[gi])
                                     : reg_mem_r[gi];
            always_ff @(posedge core_clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    reg_mem_r[gi] <= CODC_RST_VAL[gi];
                end else begin
                    reg_mem_r[gi] <= reg_mem_nxt[gi];
                end
            end
            assign rd_chain[gi+1] = rd_chain[gi] | (addr_hit[gi] ? reg_mem_r[gi]
                                                                  : CODC_RD_ZERO);
        end
    endgenerate

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // Unmapped addresses fall through the chain as zero
    assign rd_sel = rd_chain[CODC_NUM_REG];
    assign rdata_nxt = reg_rd_i ? rd_sel : CODC_RD_ZERO;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_r <= CODC_RD_ZERO;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata_o = rdata_r;

    // ------------------------------------------------------------
    // Emitter-coupled stages
    // ------------------------------------------------------------
    codc_pecl_s [CODC_NUM_PECL-1:0] pecl_nxt;
    codc_pecl_s [CODC_NUM_PECL-1:0] pecl_r;

    generate
        for (gi = 0; gi < CODC_NUM_PECL; gi++) begin : g_pecl
            wire codc_pmode_e pmode;
            assign pmode = codc_pmode_e'(reg_mem_r[gi][CODC_PECL_MODE_LSB +: 2]);
            assign pecl_nxt[gi].invert = reg_mem_r[gi][CODC_PECL_INV_BIT];
            assign pecl_nxt[gi].swing =
                codc_swing_e'(reg_mem_r[gi][CODC_PECL_SWING_LSB +: 2]);
            assign pecl_nxt[gi].drive_on = (pmode == CODC_PMODE_ON);
            assign pecl_nxt[gi].partial_pd = (pmode == CODC_PMODE_PARTIAL_PD);
            // Every off code floats the pins, partial or full
            assign pecl_nxt[gi].pins_hiz = (pmode != CODC_PMODE_ON);
        end
    endgenerate

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pecl_r <= '0;
        end else begin
            pecl_r <= pecl_nxt;
        end
    end

    assign pecl_ctrl_o = pecl_r;

    // ------------------------------------------------------------
    // Switchable stages
    // ------------------------------------------------------------
    generate
        for (gi = 0; gi < CODC_NUM_SW; gi++) begin : g_sw
            codc_sw_decode u_dec (
                .core_clk_i(core_clk_i),
                .rst_b_i(rst_b_i),
                .ctrl_i(reg_mem_r[CODC_NUM_PECL + gi]),
                .stage_o(sw_ctrl_o[gi])
            );
        end
    endgenerate

endmodule : codc_bank

//--- tb/codc_bank_asserts.sv
// Purpose: Port checks for the output driver control bank.
// Assumes: One clock, reset asynchronous and active low.
// Notes: Channels zero, one, six and seven are watched; the bench covers the rest.
`timescale 1ns/100ps
module codc_bank_asserts (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire codc_pkg::codc_addr_t reg_addr_i,
    input wire codc_pkg::codc_data_t reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire codc_pkg::codc_data_t reg_rdata_o,
    input wire codc_pkg::codc_pecl_s [codc_pkg::CODC_NUM_PECL-1:0] pecl_ctrl_o,
    input wire codc_pkg::codc_sw_s [codc_pkg::CODC_NUM_SW-1:0] sw_ctrl_o
);
    import codc_pkg::*;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    wire wr0 = reg_wr_i && reg_addr_i == CODC_OFF_PECL_ZERO;
    wire wr6 = reg_wr_i && reg_addr_i == CODC_OFF_SW_SIX;
    wire rd0 = reg_rd_i && reg_addr_i == CODC_OFF_PECL_ZERO;
    chk_pecl_inv: assert property (wr0 |-> ##2
        pecl_ctrl_o[0].invert == $past(reg_wdata_i[4], 2)) else $error("invert lag");
    chk_pecl_swing: assert property (wr0 |-> ##2
        pecl_ctrl_o[0].swing == $past(reg_wdata_i[3:2], 2)) else $error("swing");
    chk_pecl_mode: assert property (wr0 |-> ##2
        pecl_ctrl_o[0].pins_hiz == ($past(reg_wdata_i[1:0], 2) != 2'h0)) else $error("hiz");
    chk_rst_vals: assert property ($rose(rst_b_i) |=> pecl_ctrl_o[1].pins_hiz &&
        pecl_ctrl_o[0].drive_on) else $error("reset mode");
    chk_sw_lvds_pol: assert property (wr6 && !reg_wdata_i[3] |-> ##2
        sw_ctrl_o[0].true_inv == $past(reg_wdata_i[5], 2)) else $error("lvds pol");
    chk_sw_level: assert property (wr6 |-> ##2
        sw_ctrl_o[0].cmos_mode == $past(reg_wdata_i[3], 2)) else $error("level");
    chk_sw_cur: assert property (sw_ctrl_o[0].cmos_mode |->
        sw_ctrl_o[0].lvds_cur == CODC_CUR_1P75MA && !sw_ctrl_o[0].term_fifty) else $error("cur");
    chk_sw_pd: assert property (sw_ctrl_o[0].lvds_hiz |->
        !sw_ctrl_o[0].cmos_mode && !sw_ctrl_o[0].drive_on) else $error("pd");
    chk_comp_on: assert property (sw_ctrl_o[1].comp_on |->
        sw_ctrl_o[1].cmos_mode && sw_ctrl_o[1].drive_on) else $error("comp on");
    chk_rd_masked: assert property (rd0 |=>
        reg_rdata_o[7:5] == 3'h0) else $error("upper bits");
endmodule : codc_bank_asserts

bind codc_bank codc_bank_asserts u_codc_bank_asserts (.core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .pecl_ctrl_o(pecl_ctrl_o), .sw_ctrl_o(sw_ctrl_o));

//--- tb/codc_rx_model.sv
// Purpose: Board receivers fed by the ten output stages.
// Assumes: A receiver sees a clock only from a driving stage.
// Notes: Behavioural, no timing.
`timescale 1ns/100ps
module codc_rx_model (
    input wire codc_pkg::codc_pecl_s [codc_pkg::CODC_NUM_PECL-1:0] pecl_ctrl_i,
    input wire codc_pkg::codc_sw_s [codc_pkg::CODC_NUM_SW-1:0] sw_ctrl_i,
    output logic [5:0] pecl_live_o,
    output logic [3:0] sw_live_o
);
    import codc_pkg::*;
    always_comb begin
        for (int i = 0; i < CODC_NUM_PECL; i++) begin
            pecl_live_o[i] = pecl_ctrl_i[i].drive_on && !pecl_ctrl_i[i].pins_hiz;
        end
        for (int i = 0; i < CODC_NUM_SW; i++) begin
            // High-Z or held low both look dead to a receiver
            sw_live_o[i] = sw_ctrl_i[i].drive_on && !sw_ctrl_i[i].lvds_hiz
                           && !sw_ctrl_i[i].cmos_low;
        end
    end
endmodule : codc_rx_model

//--- tb/codc_bank_tb_top.sv
// Purpose: Self-checking bench for the output driver control bank.
// Assumes: Strobes one cycle each, driven after the rising edge.
// Notes: Rows cover field codes; reset and odd addresses follow.
`timescale 1ns/100ps
module codc_bank_tb_top;
    import codc_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    codc_addr_t addr = '0;
    codc_data_t wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    codc_data_t rdata;
    codc_pecl_s [CODC_NUM_PECL-1:0] pecl;
    codc_sw_s [CODC_NUM_SW-1:0] sw;
    logic [5:0] pecl_live;
    logic [3:0] sw_live;
    int mismatches = 0;
    int check_count = 0;
    int cyc = 0;
    codc_data_t d;
    // Polarity per code, bit index is the code
    localparam logic [7:0] TRUE_LUT = 8'h5a;
    localparam logic [7:0] COMP_LUT = 8'h99;
    // Register index, written byte, then the byte it must read back
    logic [19:0] rows [17] = '{20'h0ff1f, 20'h10000, 20'h20505, 20'h3e202, 20'h41818,
        20'h51313, 20'h60808, 20'h73a3a, 20'h85858, 20'h97878, 20'h69c9c, 20'h7b9b9,
        20'h8d8d8, 20'h9f8f8, 20'h62626, 20'h7c5c5, 20'h81414};
    codc_data_t rst_exp [10] = '{8'h08, 8'h0a, 8'h08, 8'h0a, 8'h08, 8'h0a,
        8'h43, 8'h43, 8'h43, 8'h43};

    always #5 core_clk_i = ~core_clk_i;

    codc_bank u_codc_bank (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .pecl_ctrl_o(pecl), .sw_ctrl_o(sw));
    codc_rx_model u_codc_rx_model (.pecl_ctrl_i(pecl), .sw_ctrl_i(sw),
        .pecl_live_o(pecl_live), .sw_live_o(sw_live));

    function automatic codc_pecl_s exp_pecl(input codc_data_t b);
        exp_pecl = {b[4], b[3:2], b[1:0] == 2'h0, b[1:0] == 2'h1, b[1:0] != 2'h0};
    endfunction : exp_pecl

    function automatic codc_sw_s exp_sw(input codc_data_t b);
        logic c;
        c = b[3];
        exp_sw = {c, c ? TRUE_LUT[b[7:5]] : b[5], c & COMP_LUT[b[7:5]], c & b[4] & ~b[0],
            c ? 2'h0 : b[2:1], ~c & b[2], ~b[0], b[0] & ~c, b[0] & c};
    endfunction : exp_sw

    task automatic wrap_up();
        if (mismatches == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (exp !== got) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic bus(input logic w, input logic r, input codc_addr_t a, input codc_data_t v);
        @(posedge core_clk_i);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= v;
    endtask : bus

    task automatic rd_chk(input codc_addr_t a, input codc_data_t exp);
        bus(1'b0, 1'b1, a, 8'h00);
        bus(1'b0, 1'b0, a, 8'h00);
        #1;
        check("read data", 16'(exp), 16'(rdata));
    endtask : rd_chk

    task automatic chk_chan(input int i, input codc_data_t b);
        if (i < CODC_NUM_PECL) begin
            check("pecl stage", 16'(exp_pecl(b)), 16'(pecl[i]));
            check("pecl live", 16'(b[1:0] == 2'h0), 16'(pecl_live[i]));
        end else begin
            check("sw stage", 16'(exp_sw(b)), 16'(sw[i-6]));
            check("sw live", 16'(!b[0]), 16'(sw_live[i-6]));
        end
    endtask : chk_chan

    // Hang guard, the whole run needs about a hundred cycles
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            mismatches++;
            wrap_up();
        end
    end

    initial begin
        repeat (12) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        for (int i = 0; i < 17; i++) begin
            bus(1'b1, 1'b0, CODC_REG_OFF[rows[i][19:16]], rows[i][15:8]);
            d = rows[i][7:0];
            rd_chk(CODC_REG_OFF[rows[i][19:16]], d);
            chk_chan(int'(rows[i][19:16]), d);
        end
        // Second reset in mid-run must restore every default
        @(posedge core_clk_i);
        rst_b_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            rd_chk(CODC_REG_OFF[i], rst_exp[i]);
            chk_chan(i, rst_exp[i]);
        end
        bus(1'b1, 1'b0, 9'h144, 8'hff);
        rd_chk(9'h144, 8'h00);
        rd_chk(9'h0f6, 8'h00);
        rd_chk(CODC_OFF_SW_NINE, 8'h43);
        wrap_up();
    end
endmodule : codc_bank_tb_top
